// ### common/prpm_map.vh
// Purpose: Constants for the PHY reset and power manager
// Assumes: 16-bit register port, byte addresses, 50 MHz clock
// Notes: Offsets are word aligned
`ifndef PRPM_MAP_VH
`define PRPM_MAP_VH
`define PRPM_A_CU_CTRL 8'h00
`define PRPM_A_FB_CTRL 8'h04
`define PRPM_A_CU_SPEC 8'h08
`define PRPM_A_FB_SPEC 8'h0C
`define PRPM_A_MODE 8'h10
`define PRPM_A_STAT 8'h14
`define PRPM_A_CHG 8'h18
`define PRPM_B_RST 15
`define PRPM_B_PD 11
`define PRPM_B_RESTART 9
`define PRPM_B_SPD 2
`define PRPM_B_KEEP 3
`define PRPM_B_EDHI 9
`define PRPM_B_EDLO 8
`define PRPM_B_AUTOSEL 0
`define PRPM_B_ENERGY 4
`define PRPM_CU_CTRL_RST 16'h0000
`define PRPM_FB_CTRL_RST 16'h0000
`define PRPM_CU_SPEC_RST 16'h0008
`define PRPM_FB_SPEC_RST 16'h0008
`define PRPM_MODE_RST 16'h0000
`define PRPM_RST_HOLD 3'h4
`define PRPM_CLK_KHZ 50000
`define PRPM_NEG_TIME_MS 5000
`define PRPM_NLP_TIME_MS 1000
`endif

// ### hdl/prpm_top.v
// Purpose: Reset and power sequencing for a single-port transceiver
// Assumes: Link, negotiation and in-use inputs come from this clock
// Notes: Register port answers every read one cycle later
// What this block does
// (R1) Copper reset clears copper circuit and pages
// (R2) Fiber reset clears fiber circuit and page
// (R3) Mode reset clears mode, power, generator
// (R4) Each reset leaves other circuits alone
// (R5) Reset bits clear themselves when done
// (R6) Power down ignores system and media
// (R7) Wake only when power-down bits clear
// (R8) Power-down bits override automatic management
// (R9) Unused circuits powered down automatically
// (R10) Power-up by bit clear issues reset
// (R11) Live energy status plus change flag
// (R12) Sleep modes copper only, not auto-select
// (R13) Two-bit field selects sleep mode
// (R14) Energy starts five second negotiation window
// (R15) Link loss in sleep mode restarts negotiation
// (R16) Active mode sends one pulse per second
// (R17) Leaving power down enters listening first
// (R18) Keep-alive bit gates MAC interface power
// (R19) Negotiation starts on all listed events
// (R20) Hardware reset pin restores all defaults
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "prpm_map.vh"
module prpm_top #(
  parameter [27:0] P_NEG_CYC = `PRPM_NEG_TIME_MS * `PRPM_CLK_KHZ,
  parameter [27:0] P_NLP_CYC = `PRPM_NLP_TIME_MS * `PRPM_CLK_KHZ
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_hardware_reset_low_pin,
  // Register port
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Media and link status
  input wire i_energy_pin,
  input wire i_copper_link,
  input wire i_fiber_link,
  input wire i_copper_an_done,
  input wire i_copper_in_use,
  input wire i_fiber_in_use,
  // Resets and negotiation starts
  output reg o_copper_rst,
  output reg o_fiber_rst,
  output reg o_mode_rst,
  output reg o_copper_an_start,
  output reg o_fiber_an_start,
  // Power and media control
  output reg o_copper_pwr_on,
  output reg o_fiber_pwr_on,
  output reg o_sig_detect_on,
  output reg o_mac_if_pwr_on,
  output reg o_sys_if_ignore,
  output reg o_copper_media_ignore,
  output reg o_fiber_media_ignore,
  output reg o_flp_en,
  output reg o_nlp_pulse
);
  localparam [3:0] S_NORM = 4'h1;
  localparam [3:0] S_LISTEN = 4'h2;
  localparam [3:0] S_NEG = 4'h4;
  localparam [3:0] S_LINK = 4'h8;

  function [2:0] rst_step;
    input [2:0] cnt;
    input start;
    begin
      if (start)
        rst_step = `PRPM_RST_HOLD;
      else if (cnt != 3'h0)
        rst_step = cnt - 3'h1;
      else
        rst_step = 3'h0;
    end
  endfunction

  reg hw_s1_r, hw_s2_r, en_s1_r, en_s2_r, en_q_r;
  wire rst_any;
  reg [15:0] cu_ctrl_r, fb_ctrl_r, cu_spec_r, fb_spec_r, mode_r;
  reg [2:0] cu_cnt_r, fb_cnt_r, md_cnt_r;
  reg [2:0] cu_cnt_nxt, fb_cnt_nxt, md_cnt_nxt;
  reg chg_r, init_r, cu_link_q_r, fb_link_q_r;
  reg keep_cu_r, keep_fb_r;
  reg [3:0] st_r, st_nxt;
  reg [27:0] neg_cnt_r, nlp_cnt_r;
  reg cu_pu_evt, fb_pu_evt, cu_restart, fb_restart;
  reg cu_go, fb_go, md_go;
  wire w_cu_ctrl, w_fb_ctrl, w_cu_spec, w_fb_spec, w_mode;
  wire cu_pd, fb_pd, ed_sel, ed_pulse_mode, cu_done, fb_done, md_done;
  wire rd_chg, cu_link_loss;

  // Hardware reset pin is asynchronous to the clock
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      hw_s1_r <= 1'b1;
      hw_s2_r <= 1'b1;
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end
    else
    begin
      hw_s1_r <= i_hardware_reset_low_pin;
      hw_s2_r <= hw_s1_r;
      en_s1_r <= i_energy_pin;
      en_s2_r <= en_s1_r;
    end
  end

  assign rst_any = i_rst | ~hw_s2_r; // R20

  assign w_cu_ctrl = i_wr & (i_addr == `PRPM_A_CU_CTRL);
  assign w_fb_ctrl = i_wr & (i_addr == `PRPM_A_FB_CTRL);
  assign w_cu_spec = i_wr & (i_addr == `PRPM_A_CU_SPEC);
  assign w_fb_spec = i_wr & (i_addr == `PRPM_A_FB_SPEC);
  assign w_mode = i_wr & (i_addr == `PRPM_A_MODE);
  assign rd_chg = i_rd & (i_addr == `PRPM_A_CHG);

  // Either copper bit alone holds copper down
  assign cu_pd = cu_ctrl_r[`PRPM_B_PD] | cu_spec_r[`PRPM_B_SPD]; // R7
  assign fb_pd = fb_ctrl_r[`PRPM_B_PD]; // R7
  // Sleep modes need the high mode bit and no auto media select
  assign ed_sel = cu_spec_r[`PRPM_B_EDHI]
                & ~mode_r[`PRPM_B_AUTOSEL]; // R12 R13
  assign ed_pulse_mode = ed_sel & cu_spec_r[`PRPM_B_EDLO]; // R13 R16
  assign cu_done = (cu_cnt_r == 3'h1);
  assign fb_done = (fb_cnt_r == 3'h1);
  assign md_done = (md_cnt_r == 3'h1);
  assign cu_link_loss = cu_link_q_r & ~i_copper_link & ~cu_pd;

  // Power-up events come only from software clearing a bit
  always @*
  begin
    cu_pu_evt = 1'b0;
    fb_pu_evt = 1'b0;
    if (w_cu_ctrl & ~i_wdata[`PRPM_B_PD] & cu_pd
        & ~cu_spec_r[`PRPM_B_SPD] & ~w_cu_spec)
      cu_pu_evt = 1'b1; // R10
    if (w_cu_spec & ~i_wdata[`PRPM_B_SPD] & cu_pd
        & ~cu_ctrl_r[`PRPM_B_PD])
      cu_pu_evt = 1'b1; // R10
    if (w_fb_ctrl & ~i_wdata[`PRPM_B_PD] & fb_pd)
      fb_pu_evt = 1'b1; // R10
    cu_restart = w_cu_ctrl & i_wdata[`PRPM_B_RESTART];
    fb_restart = w_fb_ctrl & i_wdata[`PRPM_B_RESTART];
    cu_go = (w_cu_ctrl & i_wdata[`PRPM_B_RST]) | cu_pu_evt; // R1 R10
    fb_go = (w_fb_ctrl & i_wdata[`PRPM_B_RST]) | fb_pu_evt; // R2 R10
    md_go = w_mode & i_wdata[`PRPM_B_RST]; // R3
    cu_cnt_nxt = rst_step(cu_cnt_r, cu_go);
    fb_cnt_nxt = rst_step(fb_cnt_r, fb_go);
    md_cnt_nxt = rst_step(md_cnt_r, md_go);
  end

  // Each circuit's pages revert only on its own reset or on rst_any
  always @(posedge i_sys_clk)
  begin
    if (rst_any)
    begin
      cu_ctrl_r <= `PRPM_CU_CTRL_RST; // R20
      fb_ctrl_r <= `PRPM_FB_CTRL_RST;
      cu_spec_r <= `PRPM_CU_SPEC_RST;
      fb_spec_r <= `PRPM_FB_SPEC_RST;
      mode_r <= `PRPM_MODE_RST;
      cu_cnt_r <= 3'h0;
      fb_cnt_r <= 3'h0;
      md_cnt_r <= 3'h0;
      keep_cu_r <= 1'b1;
      keep_fb_r <= 1'b1;
    end
    else
    begin
      cu_cnt_r <= cu_cnt_nxt;
      fb_cnt_r <= fb_cnt_nxt;
      md_cnt_r <= md_cnt_nxt;
      if (cu_done)
      begin
        cu_ctrl_r <= `PRPM_CU_CTRL_RST; // R1 R4 R5
        cu_spec_r <= `PRPM_CU_SPEC_RST; // R1
        keep_cu_r <= cu_spec_r[`PRPM_B_KEEP]; // R18
      end
      else
      begin
        if (w_cu_ctrl)
          cu_ctrl_r <= i_wdata & 16'h0800;
        if (w_cu_spec)
          cu_spec_r <= i_wdata & 16'h030C;
      end
      if (fb_done)
      begin
        fb_ctrl_r <= `PRPM_FB_CTRL_RST; // R2 R4 R5
        fb_spec_r <= `PRPM_FB_SPEC_RST; // R2
        keep_fb_r <= fb_spec_r[`PRPM_B_KEEP]; // R18
      end
      else
      begin
        if (w_fb_ctrl)
          fb_ctrl_r <= i_wdata & 16'h0800;
        if (w_fb_spec)
          fb_spec_r <= i_wdata & 16'h0008;
      end
      if (md_done)
        mode_r <= `PRPM_MODE_RST; // R3 R5
      else if (w_mode)
        mode_r <= i_wdata & 16'h0001;
    end
  end

  // Sleep state machine; the mode reset also restarts it
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      S_NORM:
        if (ed_sel)
          st_nxt = i_copper_link ? S_LINK : S_LISTEN;
      S_LISTEN:
        if (~ed_sel)
          st_nxt = S_NORM;
        else if (en_s2_r & ~cu_pd)
          st_nxt = S_NEG; // R14
      S_NEG:
        if (~ed_sel)
          st_nxt = S_NORM;
        else if (i_copper_an_done)
          st_nxt = S_LINK; // R14
        else if (neg_cnt_r == 28'h1)
          st_nxt = S_LISTEN; // R14
      S_LINK:
        if (~ed_sel)
          st_nxt = S_NORM;
        else if (cu_link_loss)
          st_nxt = S_NEG; // R15
      default:
        st_nxt = S_NORM;
    endcase
    if (cu_pd)
      st_nxt = ed_sel ? S_LISTEN : S_NORM; // R17
  end

  always @(posedge i_sys_clk)
  begin
    if (rst_any | md_done)
    begin
      st_r <= S_NORM; // R3
      neg_cnt_r <= 28'h0;
      nlp_cnt_r <= 28'h0;
      o_nlp_pulse <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if ((st_nxt == S_NEG) && (st_r != S_NEG))
        neg_cnt_r <= P_NEG_CYC; // R14
      else if (neg_cnt_r != 28'h0)
        neg_cnt_r <= neg_cnt_r - 28'h1;
      // Pulse timer only runs while listening in active mode
      o_nlp_pulse <= 1'b0;
      if ((st_r == S_LISTEN) && ed_pulse_mode && ~cu_pd)
      begin
        if (nlp_cnt_r <= 28'h1)
        begin
          nlp_cnt_r <= P_NLP_CYC; // R16
          // No pulse on the edge that leaves listening
          o_nlp_pulse <= (nlp_cnt_r == 28'h1)
            & (st_nxt == S_LISTEN); // R16
        end
        else
          nlp_cnt_r <= nlp_cnt_r - 28'h1;
      end
      else
        nlp_cnt_r <= 28'h0;
    end
  end

  // Energy status; a new change beats a read clear
  always @(posedge i_sys_clk)
  begin
    if (rst_any)
    begin
      en_q_r <= 1'b0;
      chg_r <= 1'b0;
    end
    else
    begin
      en_q_r <= en_s2_r;
      if (en_q_r != en_s2_r)
        chg_r <= 1'b1; // R11
      else if (rd_chg)
        chg_r <= 1'b0;
    end
  end

  // Negotiation starts; init covers power-up and pin reset
  always @(posedge i_sys_clk)
  begin
    if (rst_any)
    begin
      init_r <= 1'b1;
      cu_link_q_r <= 1'b0;
      fb_link_q_r <= 1'b0;
      o_copper_an_start <= 1'b0;
      o_fiber_an_start <= 1'b0;
    end
    else
    begin
      init_r <= 1'b0;
      cu_link_q_r <= i_copper_link;
      fb_link_q_r <= i_fiber_link;
      o_copper_an_start <= ~cu_pd & (init_r | cu_done | cu_restart
        | cu_link_loss | ((st_r == S_LISTEN) && (st_nxt == S_NEG))); // R19
      o_fiber_an_start <= ~fb_pd & (init_r | fb_done | fb_restart
        | (fb_link_q_r & ~i_fiber_link)); // R19
    end
  end

  // Power outputs; pd bits always win over in-use requests
  always @(posedge i_sys_clk)
  begin
    if (rst_any)
    begin
      o_copper_rst <= 1'b1; // R20
      o_fiber_rst <= 1'b1;
      o_mode_rst <= 1'b1;
      o_copper_pwr_on <= 1'b0;
      o_fiber_pwr_on <= 1'b0;
      o_sig_detect_on <= 1'b0;
      o_mac_if_pwr_on <= 1'b0;
      o_sys_if_ignore <= 1'b1;
      o_copper_media_ignore <= 1'b1;
      o_fiber_media_ignore <= 1'b1;
      o_flp_en <= 1'b0;
    end
    else
    begin
      o_copper_rst <= (cu_cnt_nxt != 3'h0); // R1 R4
      o_fiber_rst <= (fb_cnt_nxt != 3'h0); // R2 R4
      o_mode_rst <= (md_cnt_nxt != 3'h0); // R3 R4
      o_copper_pwr_on <= ~cu_pd & i_copper_in_use
        & (st_nxt != S_LISTEN); // R8 R9 R14
      o_fiber_pwr_on <= ~fb_pd & i_fiber_in_use; // R8 R9
      o_sig_detect_on <= ~cu_pd & i_copper_in_use; // R14
      o_mac_if_pwr_on <= ~((cu_pd | (st_nxt == S_LISTEN)) & fb_pd)
        | keep_cu_r | keep_fb_r; // R18
      o_sys_if_ignore <= cu_pd | fb_pd; // R6
      o_copper_media_ignore <= cu_pd; // R6 R7
      o_fiber_media_ignore <= fb_pd; // R6 R7
      o_flp_en <= (st_nxt == S_NEG) & ~cu_pd; // R14
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk)
  begin
    if (rst_any)
      o_rdata <= 16'h0000;
    else if (!i_rd)
      o_rdata <= 16'h0000;
    else
    begin
      case (i_addr)
        `PRPM_A_CU_CTRL:
          o_rdata <= cu_ctrl_r | {(cu_cnt_r != 3'h0), 15'h0000}; // R5
        `PRPM_A_FB_CTRL:
          o_rdata <= fb_ctrl_r | {(fb_cnt_r != 3'h0), 15'h0000}; // R5
        `PRPM_A_CU_SPEC:
          o_rdata <= cu_spec_r;
        `PRPM_A_FB_SPEC:
          o_rdata <= fb_spec_r;
        `PRPM_A_MODE:
          o_rdata <= mode_r | {(md_cnt_r != 3'h0), 15'h0000}; // R5
        `PRPM_A_STAT:
          o_rdata <= {fb_pd, cu_pd, 9'h000, en_s2_r, st_r}; // R11
        `PRPM_A_CHG:
          o_rdata <= {11'h000, chg_r, 4'h0}; // R11
        default:
          o_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // prpm_top

// ### bench/prpm_host.sv
// Purpose: Management host model driving the register port
// Assumes: One-cycle strobes, read data one cycle after the strobe
// Notes: The bench calls wr and rd through the instance
`timescale 1ns/1ps
module prpm_host (
  // Clock and read data
  input wire i_sys_clk,
  input wire [15:0] i_rdata,
  // Register port
  output logic [7:0] o_addr = 8'h00,
  output logic [15:0] o_wdata = 16'h0000,
  output logic o_wr = 1'h0,
  output logic o_rd = 1'h0
);
  // Extra edge after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'h1;
    @(posedge i_sys_clk);
    o_wr <= 1'h0;
    @(posedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    o_addr <= a;
    o_rd <= 1'h1;
    @(posedge i_sys_clk);
    o_rd <= 1'h0;
    #1 d = i_rdata;
    @(posedge i_sys_clk);
  endtask
endmodule // prpm_host

// ### bench/prpm_top_sva.sv
// Purpose: Port-level checks of the reset and power manager
// Assumes: Pin reset never lands inside a reset pulse
// Notes: Bound into every prpm_top
`timescale 1ns/1ps
`include "prpm_map.vh"
module prpm_top_sva (
  // Clock, reset, register port
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  // Media inputs
  input wire i_copper_link,
  input wire i_fiber_in_use,
  // Outputs watched
  input wire o_copper_rst,
  input wire o_fiber_rst,
  input wire o_mode_rst,
  input wire o_copper_an_start,
  input wire o_copper_pwr_on,
  input wire o_fiber_pwr_on,
  input wire o_copper_media_ignore,
  input wire o_fiber_media_ignore,
  input wire o_flp_en,
  input wire o_nlp_pulse
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire cu_go = i_wr && i_addr == `PRPM_A_CU_CTRL && i_wdata[15];
  wire fb_go = i_wr && i_addr == `PRPM_A_FB_CTRL && i_wdata[15];
  wire md_go = i_wr && i_addr == `PRPM_A_MODE && i_wdata[15];
  sequence s_cu_done;
    o_copper_rst[*4] ##1 (!o_copper_rst && o_copper_an_start);
  endsequence
  sequence s_fb_done;
    o_fiber_rst[*4] ##1 !o_fiber_rst;
  endsequence
  sequence s_md_done;
    o_mode_rst[*4] ##1 !o_mode_rst;
  endsequence
  a_cu_rst_len:
    assert property (cu_go && !o_copper_rst |=> s_cu_done)
    else $error("copper reset pulse wrong");
  a_fb_rst_len:
    assert property (fb_go && !o_fiber_rst |=> s_fb_done)
    else $error("fiber reset pulse wrong");
  a_mode_rst_len:
    assert property (md_go && !o_mode_rst |=> s_md_done)
    else $error("mode reset pulse wrong");
  a_cu_rst_alone:
    assert property (cu_go && !fb_go && !o_fiber_rst && !o_mode_rst
      |=> !o_fiber_rst && !o_mode_rst)
    else $error("copper reset disturbed another circuit");
  a_cu_pd_gates:
    assert property (o_copper_media_ignore |-> !o_copper_pwr_on)
    else $error("copper powered while powered down");
  a_fb_pd_gates:
    assert property (o_fiber_media_ignore |-> !o_fiber_pwr_on)
    else $error("fiber powered while powered down");
  a_unused_off:
    assert property (!i_fiber_in_use |=> !o_fiber_pwr_on)
    else $error("unused fiber left powered");
  a_link_loss:
    assert property ($fell(i_copper_link) && !o_copper_media_ignore
      && !o_copper_rst |=> o_copper_an_start)
    else $error("no negotiation start on link loss");
  a_nlp_listen:
    assert property (o_nlp_pulse |-> !o_copper_pwr_on && !o_flp_en)
    else $error("link pulse outside listening");
endmodule // prpm_top_sva
bind prpm_top prpm_top_sva u_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_copper_link(i_copper_link), .i_fiber_in_use(i_fiber_in_use),
  .o_copper_rst(o_copper_rst), .o_fiber_rst(o_fiber_rst),
  .o_mode_rst(o_mode_rst), .o_copper_an_start(o_copper_an_start),
  .o_copper_pwr_on(o_copper_pwr_on), .o_fiber_pwr_on(o_fiber_pwr_on),
  .o_copper_media_ignore(o_copper_media_ignore),
  .o_fiber_media_ignore(o_fiber_media_ignore), .o_flp_en(o_flp_en),
  .o_nlp_pulse(o_nlp_pulse));

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the reset and power manager
// Assumes: Shortened negotiation window and pulse period
// Notes: Port checks at the falling edge, after updates land
`timescale 1ns/1ps
`include "prpm_map.vh"
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic en = 1'h0, cl = 1'h0, fl = 1'h1, ad = 1'h0, cu = 1'h1, fu = 1'h1;
  logic hw = 1'h1;
  logic [7:0] addr;
  logic [15:0] wd, rdat;
  logic wr, rd;
  wire cr, fr, mr, as, fs, cp, fp, sd, mp, si, ci, fi, fe, np;
  int fails = 0, comparisons = 0, cyc = 0, n_as = 0, n_np = 0;
  always #10 clk = ~clk;
  prpm_host u_host (.i_sys_clk(clk), .i_rdata(rdat), .o_addr(addr),
    .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  prpm_top #(.P_NEG_CYC(28'h14), .P_NLP_CYC(28'h8)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_hardware_reset_low_pin(hw),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .i_energy_pin(en), .i_copper_link(cl), .i_fiber_link(fl),
    .i_copper_an_done(ad), .i_copper_in_use(cu), .i_fiber_in_use(fu),
    .o_copper_rst(cr), .o_fiber_rst(fr), .o_mode_rst(mr),
    .o_copper_an_start(as), .o_fiber_an_start(fs), .o_copper_pwr_on(cp),
    .o_fiber_pwr_on(fp), .o_sig_detect_on(sd), .o_mac_if_pwr_on(mp),
    .o_sys_if_ignore(si), .o_copper_media_ignore(ci),
    .o_fiber_media_ignore(fi), .o_flp_en(fe), .o_nlp_pulse(np));
  // Pulse counters, so no one-cycle pulse is missed between reads
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (as === 1'h1)
      n_as <= n_as + 1;
    if (np === 1'h1)
      n_np <= n_np + 1;
    if (cyc == 3000)
    begin
      fails++;
      stop_test;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] m, e);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(d & m, e);
  endtask
  task automatic t_defaults;
    rc(`PRPM_A_CU_CTRL, 16'hFFFF, `PRPM_CU_CTRL_RST);
    rc(`PRPM_A_CU_SPEC, 16'hFFFF, `PRPM_CU_SPEC_RST);
    rc(`PRPM_A_FB_SPEC, 16'hFFFF, `PRPM_FB_SPEC_RST);
    rc(`PRPM_A_MODE, 16'hFFFF, `PRPM_MODE_RST);
    rc(8'h1C, 16'hFFFF, 16'h0000);
    $display("defaults done");
  endtask
  task automatic t_soft;
    u_host.wr(`PRPM_A_FB_SPEC, 16'h0000);
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0100);
    u_host.wr(`PRPM_A_CU_CTRL, 16'h8000);
    rc(`PRPM_A_CU_CTRL, 16'h8000, 16'h8000);
    repeat (6) @(posedge clk);
    rc(`PRPM_A_CU_CTRL, 16'hFFFF, 16'h0000);
    rc(`PRPM_A_CU_SPEC, 16'hFFFF, `PRPM_CU_SPEC_RST);
    rc(`PRPM_A_FB_SPEC, 16'hFFFF, 16'h0000);
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0000);
    u_host.wr(`PRPM_A_FB_CTRL, 16'h8000);
    repeat (6) @(posedge clk);
    rc(`PRPM_A_FB_SPEC, 16'hFFFF, `PRPM_FB_SPEC_RST);
    rc(`PRPM_A_CU_SPEC, 16'hFFFF, 16'h0000);
    // Auto select stays set until the mode reset clears it
    u_host.wr(`PRPM_A_MODE, 16'h0001);
    u_host.wr(`PRPM_A_MODE, 16'h8001);
    repeat (6) @(posedge clk);
    rc(`PRPM_A_MODE, 16'hFFFF, `PRPM_MODE_RST);
    $display("soft resets done");
  endtask
  task automatic t_power;
    u_host.wr(`PRPM_A_CU_CTRL, 16'h0800);
    fu <= 1'h0;
    @(negedge clk);
    chk({ci, si, cp, sd}, 4'hC);
    @(posedge clk);
    @(negedge clk);
    chk(fp, 1'h0);
    @(posedge clk);
    fu <= 1'h1;
    // Both circuits down, keep-alive latched low by the earlier resets
    u_host.wr(`PRPM_A_FB_CTRL, 16'h0800);
    @(negedge clk);
    chk(mp, 1'h0);
    @(posedge clk);
    u_host.wr(`PRPM_A_FB_CTRL, 16'h0000);
    // Host wakes copper only through both bits
    u_host.wr(`PRPM_A_CU_SPEC, 16'h000C);
    u_host.wr(`PRPM_A_CU_CTRL, 16'h0000);
    @(negedge clk);
    chk({cr, ci}, 2'h1);
    @(posedge clk);
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0008);
    @(negedge clk);
    chk(cr, 1'h1);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(cp, 1'h1);
    @(posedge clk);
    u_host.wr(`PRPM_A_FB_CTRL, 16'h0800);
    @(negedge clk);
    chk({fi, si, fp}, 3'h6);
    @(posedge clk);
    u_host.wr(`PRPM_A_FB_CTRL, 16'h0000);
    @(negedge clk);
    chk(fr, 1'h1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(fs, 1'h1);
    repeat (3) @(posedge clk);
    $display("power down done");
  endtask
  task automatic t_sleep;
    int b;
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0308);
    rc(`PRPM_A_STAT, 16'h000F, 16'h0002);
    b = n_np;
    // First pulse comes one period plus one cycle after listening starts
    repeat (33) @(posedge clk);
    chk(16'(n_np - b), 16'h0004);
    u_host.wr(`PRPM_A_MODE, 16'h0001);
    b = n_np;
    repeat (32) @(posedge clk);
    chk(16'(n_np - b), 16'h0000);
    u_host.wr(`PRPM_A_MODE, 16'h0000);
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0208);
    b = n_np;
    repeat (32) @(posedge clk);
    chk(16'(n_np - b), 16'h0000);
    en <= 1'h1;
    repeat (4) @(posedge clk);
    rc(`PRPM_A_STAT, 16'h001F, 16'h0014);
    @(negedge clk);
    chk(fe, 1'h1);
    @(posedge clk);
    rc(`PRPM_A_CHG, 16'h0010, 16'h0010);
    rc(`PRPM_A_CHG, 16'h0010, 16'h0000);
    en <= 1'h0;
    repeat (25) @(posedge clk);
    rc(`PRPM_A_STAT, 16'h000F, 16'h0002);
    en <= 1'h1;
    repeat (6) @(posedge clk);
    ad <= 1'h1;
    cl <= 1'h1;
    repeat (2) @(posedge clk);
    rc(`PRPM_A_STAT, 16'h000F, 16'h0008);
    b = n_as;
    {en, ad, cl} <= 3'h0;
    repeat (3) @(posedge clk);
    chk(16'(n_as - b), 16'h0001);
    rc(`PRPM_A_STAT, 16'h000F, 16'h0004);
    u_host.wr(`PRPM_A_CU_SPEC, 16'h0108);
    rc(`PRPM_A_STAT, 16'h000F, 16'h0001);
    b = n_as;
    u_host.wr(`PRPM_A_CU_CTRL, 16'h0200);
    repeat (2) @(posedge clk);
    chk(16'(n_as - b), 16'h0001);
    $display("sleep modes done");
  endtask
  task automatic t_pin;
    u_host.wr(`PRPM_A_CU_CTRL, 16'h0800);
    hw <= 1'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({cr, fr, mr}, 3'h7);
    @(posedge clk);
    hw <= 1'h1;
    repeat (3) @(posedge clk);
    rc(`PRPM_A_CU_CTRL, 16'hFFFF, `PRPM_CU_CTRL_RST);
    rc(`PRPM_A_CU_SPEC, 16'hFFFF, `PRPM_CU_SPEC_RST);
    $display("pin reset done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_defaults;
    t_soft;
    t_power;
    t_sleep;
    t_pin;
    stop_test;
  end
endmodule // tb_top
